// ---- design/lct_legacy_wrap.sv ----
// Legacy pin mapping: strobe gating and shared data mux
`timescale 1ns/100ps
`default_nettype none
module lct_legacy_wrap
	import lct_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Wrapper side
	lct_wrap_if.wrap w
);
	// Write strobe low only for selected writes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			w.wr_n <= 1'b1;
		end else begin
			w.wr_n <= ~(~w.cs_n & ~w.rw_n); // RL18
		end
	end

	// Memory data wins when memory drives; host otherwise
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			w.shared_din <= 16'h0000;
			w.data_en    <= 1'b0;
		end else begin
			w.shared_din <= w.mem_den ? w.mem_din : w.host_din; // RL19
			w.data_en    <= w.mem_den | w.host_den; // RL19
		end
	end

	a_strobe_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!w.cs_n && !w.rw_n) |=> !w.wr_n) // RL18
		else $error("write strobe not asserted for select write");
	a_den_merge: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(w.mem_den || w.host_den) |=> w.data_en) // RL19
		else $error("data enable missing");
endmodule
`default_nettype wire

// ---- design/lct_mon_ptr.sv ----
// Monitor descriptor pointer with block-count wrap
`timescale 1ns/100ps
`default_nettype none
`include "lct_params.svh"
module lct_mon_ptr
	import lct_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Control
	input  wire logic [15:0] base_addr,
	input  wire logic [15:0] msg_count,
	input  wire logic        restart,
	input  wire logic        msg_done,
	// Results
	output logic      [15:0] ptr_q,
	output logic      [15:0] iaw_q,
	output logic             blk_irq_q
);
	lct_mon_state_t state_q;
	logic [15:0]    cnt_q;

	// Pointer walk: N messages, interrupt, one extra, reload
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q   <= LCT_MON_IDLE;
			ptr_q     <= 16'h0000;
			cnt_q     <= 16'h0000;
			iaw_q     <= 16'h0000;
			blk_irq_q <= 1'b0;
		end else begin
			blk_irq_q <= 1'b0;
			if (restart) begin
				state_q <= LCT_MON_COUNT;
				ptr_q   <= base_addr;
				cnt_q   <= 16'h0000;
			end else if (msg_done) begin
				unique case (state_q)
				LCT_MON_IDLE: begin
				end
				LCT_MON_COUNT: begin
					ptr_q <= ptr_q + `LCT_DESC_STRIDE; // RL20
					if (cnt_q + 16'h0001 >= msg_count) begin
						blk_irq_q <= 1'b1; // RL7
						iaw_q     <= ptr_q; // RL9
						state_q   <= LCT_MON_EXTRA; // RL7
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				LCT_MON_EXTRA: begin
					ptr_q   <= base_addr; // RL8
					cnt_q   <= 16'h0000;
					state_q <= LCT_MON_COUNT;
				end
				default: state_q <= LCT_MON_IDLE;
				endcase
			end
		end
	end

	sequence s_extra_done;
		state_q == LCT_MON_EXTRA && msg_done && !restart;
	endsequence
	a_ptr_reload: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_extra_done |=> ptr_q == $past(base_addr)) // RL8
		else $error("pointer not reloaded after extra message");
	a_irq_iaw: assert property (@(posedge ref_clk) disable iff (!rst_b)
		blk_irq_q |-> iaw_q == ptr_q - `LCT_DESC_STRIDE) // RL9
		else $error("interrupt address word wrong");
	a_no_reset_at_irq: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		blk_irq_q |-> state_q == LCT_MON_EXTRA) // RL7
		else $error("pointer reset at block count");
endmodule
`default_nettype wire

// ---- design/lct_params.svh ----
// Constants for the legacy-compatibility terminal logic
`ifndef LCT_PARAMS_SVH
`define LCT_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ------------------------------------------------------------
`define LCT_ADDR_W          4
`define LCT_OFS_CTRL        4'h0
`define LCT_OFS_TIMETAG     4'h7
`define LCT_OFS_HEALTH      4'h6
`define LCT_OFS_MON_BASE    4'h8
`define LCT_OFS_MON_COUNT   4'h9
`define LCT_OFS_INT_ADDR    4'ha
`define LCT_OFS_MON_PTR     4'hb
`define LCT_OFS_STATE       4'hc
`define LCT_OFS_LEGAL       4'hd

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LCT_HS_MEMFAIL      15
`define LCT_HS_LOOPFAIL     14
`define LCT_HS_TAPAR        13
`define LCT_HS_TOUT_A       11
`define LCT_HS_TOUT_B       10
`define LCT_INFO_BCAST      5
`define LCT_CTRL_BUFMODE    6
`define LCT_CTRL_RT_EN      0

// ------------------------------------------------------------
// Reset values and fixed numbers
// ------------------------------------------------------------
`define LCT_VERSION_CODE    10'h0a5
`define LCT_LEGAL_PRESET    16'hffff
`define LCT_DESC_STRIDE     16'h0008
`define LCT_WORD_ZERO       16'h0000

`endif

// ---- design/lct_pkg.sv ----
// Types shared by the legacy-compatibility terminal logic
package lct_pkg;
	typedef logic [15:0] lct_word_t;
	typedef enum logic [2:0] {
		LCT_MON_IDLE  = 3'b001,
		LCT_MON_COUNT = 3'b010,
		LCT_MON_EXTRA = 3'b100
	} lct_mon_state_t;
endpackage

// ---- design/lct_terminal.sv ----
// Top of the legacy-compatibility terminal logic
// ------------------------------------------------------------
// Notes on behaviour
// [RL1] Legalization registers preset from the build parameter at reset.
// [RL2] Broadcast messages set bit 5 of the information word.
// [RL3] Reset RT code resets decoder and clears time tag register 7.
// [RL4] Reset RT code re-enables both bus channels.
// [RL5] Reset RT code re-enables terminal flag reporting.
// [RL6] Reset RT code leaves execution active asserted.
// [RL7] Monitor stores N messages, interrupts, pointer not reset yet.
// [RL8] After the extra message the pointer reloads the base.
// [RL9] Interrupt address word takes last processed descriptor.
// [RL10] Health bit 15 set on memory access failure.
// [RL11] Health bit 14 set on loopback mismatch.
// [RL12] Health bit 13 set on terminal address parity error.
// [RL13] Health bits 11 and 10 set on bus A and B timeouts.
// [RL14] Hardware never sets bit 12 or 9:0; host writes any bit.
// [RL15] Bits 9:0 reset to the build-time version code.
// [RL16] Control bit 6 buffer mode is ignored; memory is direct.
// [RL17] Host performs all initialization; no self-initialization.
// [RL18] Host write strobes low only for select-low writes.
// [RL19] Shared data input muxed; data enable is either enable.
// [RL20] Descriptor pointer advances by eight per message.
// [RL21] Legacy interrupts inverted; terminal active low while busy.
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "lct_params.svh"
module lct_terminal
	import lct_pkg::*;
#(
	parameter logic [15:0] legalization_preset_param = `LCT_LEGAL_PRESET,
	parameter logic [9:0]  version_code = `LCT_VERSION_CODE // Arbitrary
)
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Protocol events
	input  wire logic        reset_rt_code,
	input  wire logic        tx_shutdown_a,
	input  wire logic        tx_shutdown_b,
	input  wire logic        inhibit_flag_code,
	input  wire logic        msg_done,
	input  wire logic        msg_bcast,
	input  wire logic [15:0] msg_info,
	input  wire logic        tick_tag,
	input  wire logic        mon_msg_done,
	// Fault events
	input  wire logic        mem_fail,
	input  wire logic        loop_fail,
	input  wire logic        tapar_err,
	input  wire logic        tout_a,
	input  wire logic        tout_b,
	// Core status
	input  wire logic        core_busy,
	input  wire logic        high_priority_irq,
	input  wire logic        message_irq,
	// Legacy pins
	input  wire logic        legacy_chip_select_n,
	input  wire logic        legacy_read_write_n,
	input  wire logic [15:0] memory_read_data_in,
	input  wire logic [15:0] host_write_data_in,
	input  wire logic        memory_data_out_enable,
	input  wire logic        host_data_out_enable,
	output logic             host_write_strobe_n,
	output logic             host_write_n,
	output logic      [15:0] legacy_shared_data_in,
	output logic             legacy_data_enable,
	output logic             legacy_priority_irq_n,
	output logic             legacy_message_irq_n,
	output logic             terminal_active_n,
	// Terminal status
	output logic      [15:0] info_word_q,
	output logic             execution_active,
	output logic             chan_a_en_q,
	output logic             chan_b_en_q,
	output logic             term_flag_en_q,
	output logic             decoder_reset_q,
	output logic             mon_blk_irq
);
	// ------------------------------------------------------------
	// Local state
	// ------------------------------------------------------------
	lct_word_t ctrl_q;
	lct_word_t timetag_q;
	lct_word_t health_q;
	lct_word_t legal_q;
	lct_word_t mon_base_q;
	lct_word_t mon_count_q;
	lct_word_t mon_ptr;
	lct_word_t interrupt_address_word;
	logic      mon_irq;
	logic      mon_restart_q;
	lct_word_t rdata_d;

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	lct_wrap_if wif ();

	assign wif.cs_n     = legacy_chip_select_n;
	assign wif.rw_n     = legacy_read_write_n;
	assign wif.mem_din  = memory_read_data_in;
	assign wif.host_din = host_write_data_in;
	assign wif.mem_den  = memory_data_out_enable;
	assign wif.host_den = host_data_out_enable;

	lct_legacy_wrap u_wrap (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.w       (wif.wrap)
	);

	// Both strobe outputs share the wrapper's registered strobe
	assign host_write_strobe_n   = wif.wr_n; // RL18
	assign host_write_n          = wif.wr_n; // RL18
	assign legacy_shared_data_in = wif.shared_din; // RL19
	assign legacy_data_enable    = wif.data_en; // RL19

	lct_mon_ptr u_mon (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.base_addr (mon_base_q),
		.msg_count (mon_count_q),
		.restart   (mon_restart_q),
		.msg_done  (mon_msg_done),
		.ptr_q     (mon_ptr),
		.iaw_q     (interrupt_address_word),
		.blk_irq_q (mon_irq)
	);
	assign mon_blk_irq = mon_irq;

	// ------------------------------------------------------------
	// Control register and monitor setup
	// ------------------------------------------------------------
	// Bit 6 is stored for readback only: no buffer path exists
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q        <= 16'h0000;
			mon_base_q    <= 16'h0000;
			mon_count_q   <= 16'h0000;
			mon_restart_q <= 1'b0;
		end else begin
			mon_restart_q <= 1'b0;
			if (reg_wr) begin
				unique case (reg_addr)
				`LCT_OFS_CTRL:      ctrl_q <= reg_wdata; // RL16
				`LCT_OFS_MON_BASE: begin
					mon_base_q    <= reg_wdata;
					mon_restart_q <= 1'b1;
				end
				`LCT_OFS_MON_COUNT: mon_count_q <= reg_wdata;
				default: begin
				end
				endcase
			end
		end
	end

	// Legalization preset; host may overwrite afterwards
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			legal_q <= legalization_preset_param; // RL1
		end else if (reg_wr && reg_addr == `LCT_OFS_LEGAL) begin
			legal_q <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// Reset RT mode code handling
	// ------------------------------------------------------------
	// Time tag counts ticks; Reset RT clear outranks host write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			timetag_q <= 16'h0000;
		end else if (reset_rt_code) begin
			timetag_q <= 16'h0000; // RL3
		end else if (reg_wr && reg_addr == `LCT_OFS_TIMETAG) begin
			timetag_q <= reg_wdata;
		end else if (tick_tag) begin
			timetag_q <= timetag_q + 16'h0001;
		end
	end

	// Decoder reset pulse lasts one cycle after the code
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			decoder_reset_q <= 1'b0;
		end else begin
			decoder_reset_q <= reset_rt_code; // RL3
		end
	end

	// Reset RT overrides any shutdown or inhibit in the same cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			chan_a_en_q    <= 1'b1;
			chan_b_en_q    <= 1'b1;
			term_flag_en_q <= 1'b1;
		end else if (reset_rt_code) begin
			chan_a_en_q    <= 1'b1; // RL4
			chan_b_en_q    <= 1'b1; // RL4
			term_flag_en_q <= 1'b1; // RL5
		end else begin
			if (tx_shutdown_a)
				chan_a_en_q <= 1'b0;
			if (tx_shutdown_b)
				chan_b_en_q <= 1'b0;
			if (inhibit_flag_code)
				term_flag_en_q <= 1'b0;
		end
	end

	// Execution active follows the control enable only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			execution_active <= 1'b0;
		end else begin
			execution_active <= ctrl_q[`LCT_CTRL_RT_EN]; // RL6
		end
	end

	// ------------------------------------------------------------
	// Information word
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			info_word_q <= 16'h0000;
		end else if (msg_done) begin
			info_word_q <= msg_info;
			info_word_q[`LCT_INFO_BCAST] <= msg_bcast; // RL2
		end
	end

	// ------------------------------------------------------------
	// Health status word
	// ------------------------------------------------------------
	// Hardware sets win over a host write in the same cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			health_q <= {6'h00, version_code}; // RL15
		end else begin
			if (reg_wr && reg_addr == `LCT_OFS_HEALTH)
				health_q <= reg_wdata; // RL14
			if (mem_fail)
				health_q[`LCT_HS_MEMFAIL] <= 1'b1; // RL10
			if (loop_fail)
				health_q[`LCT_HS_LOOPFAIL] <= 1'b1; // RL11
			if (tapar_err)
				health_q[`LCT_HS_TAPAR] <= 1'b1; // RL12
			if (tout_a)
				health_q[`LCT_HS_TOUT_A] <= 1'b1; // RL13
			if (tout_b)
				health_q[`LCT_HS_TOUT_B] <= 1'b1; // RL13
		end
	end

	// ------------------------------------------------------------
	// Legacy status pins
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			legacy_priority_irq_n <= 1'b1;
			legacy_message_irq_n  <= 1'b1;
			terminal_active_n     <= 1'b1;
		end else begin
			legacy_priority_irq_n <= ~high_priority_irq; // RL21
			legacy_message_irq_n  <= ~message_irq; // RL21
			terminal_active_n     <= ~core_busy; // RL21
		end
	end

	// ------------------------------------------------------------
	// Register read path
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = 16'h0000;
		unique case (reg_addr)
		`LCT_OFS_CTRL:      rdata_d = ctrl_q;
		`LCT_OFS_HEALTH:    rdata_d = health_q;
		`LCT_OFS_TIMETAG:   rdata_d = timetag_q;
		`LCT_OFS_MON_BASE:  rdata_d = mon_base_q;
		`LCT_OFS_MON_COUNT: rdata_d = mon_count_q;
		`LCT_OFS_INT_ADDR:  rdata_d = interrupt_address_word;
		`LCT_OFS_MON_PTR:   rdata_d = mon_ptr;
		`LCT_OFS_STATE:     rdata_d = {11'h000, execution_active,
			term_flag_en_q, chan_b_en_q, chan_a_en_q, mon_irq};
		`LCT_OFS_LEGAL:     rdata_d = legal_q;
		default:            rdata_d = 16'h0000;
		endcase
	end

	// Read data valid in the cycle after the strobe only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_reset_rt;
		reset_rt_code;
	endsequence
	a_tag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_reset_rt |=> timetag_q == 16'h0000 && decoder_reset_q) // RL3
		else $error("time tag not cleared");
	a_chan_reenable: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		s_reset_rt |=> chan_a_en_q && chan_b_en_q) // RL4
		else $error("channels not re-enabled");
	a_flag_reenable: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		s_reset_rt |=> term_flag_en_q) // RL5
		else $error("terminal flag not re-enabled");
	a_exec_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(reset_rt_code && execution_active && ctrl_q[0]) |=>
			execution_active) // RL6
		else $error("execution active dropped");
	a_bcast_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(msg_done && msg_bcast) |=> info_word_q[5]) // RL2
		else $error("broadcast bit missing");
	a_memfail_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
		mem_fail |=> health_q[15]) // RL10
		else $error("memory fail bit not set");
	a_loop_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
		loop_fail |=> health_q[14]) // RL11
		else $error("loopback fail bit not set");
	a_tapar_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
		tapar_err |=> health_q[13]) // RL12
		else $error("address parity bit not set");
	a_tout_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(tout_a || tout_b) |=> (health_q[11] || !tout_a)
			&& (health_q[10] || !tout_b)) // RL13
		else $error("timeout bit not set");
	a_hs_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == 4'h6) |=>
			health_q[12] == $past(health_q[12])) // RL14
		else $error("bit 12 changed by hardware");
	a_irq_invert: assert property (@(posedge ref_clk) disable iff (!rst_b)
		high_priority_irq |=> !legacy_priority_irq_n) // RL21
		else $error("priority interrupt not inverted");
endmodule
`default_nettype wire

// ---- design/lct_wrap_if.sv ----
// Interface carrying the legacy wrapper signals between modules
`timescale 1ns/100ps
`default_nettype none
interface lct_wrap_if;
	import lct_pkg::*;
	logic      cs_n;
	logic      rw_n;
	logic      wr_n;
	lct_word_t mem_din;
	lct_word_t host_din;
	logic      mem_den;
	logic      host_den;
	lct_word_t shared_din;
	logic      data_en;
	modport core (output cs_n, rw_n, mem_din, host_din, mem_den, host_den,
		input wr_n, shared_din, data_en);
	modport wrap (input cs_n, rw_n, mem_din, host_din, mem_den, host_den,
		output wr_n, shared_din, data_en);
endinterface
`default_nettype wire

// ---- dv/lct_host_model.sv ----
// Legacy host processor and backend memory model on the wrapper pins
`timescale 1ns/100ps
`default_nettype none
module lct_host_model
	import lct_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Command: 0 idle, 1 host write, 2 host read, 3 memory data
	input  wire logic [1:0] op,
	input  wire lct_word_t  data,
	// Legacy pins
	output logic            cs_n,
	output logic            rw_n,
	output logic            host_den,
	output logic            mem_den,
	output lct_word_t       host_wdata,
	output lct_word_t       mem_rdata
);
	lct_word_t last_q;

	// Released buses flip every idle cycle and carry inverted data during a command, so a stale value never looks valid
	always_ff @(posedge ref_clk) begin
		last_q <= (op != 2'h0) ? data : ~last_q;
	end

	// Cycle decode; only the addressed party drives real data
	always_comb begin
		cs_n       = !(op == 2'h1 || op == 2'h2);
		rw_n       = (op != 2'h1);
		host_den   = !cs_n;
		mem_den    = (op == 2'h3);
		host_wdata = !cs_n ? data : ~last_q;
		mem_rdata  = mem_den ? data : ~last_q;
	end
endmodule
`default_nettype wire

// ---- dv/lct_terminal_tb.sv ----
// Self-checking testbench for the legacy-compatibility terminal logic
`timescale 1ns/100ps
`default_nettype none
module lct_terminal_tb
	import lct_pkg::*;
;
	typedef struct packed {
		logic [1:0] op;
		logic [2:0] irq;
		logic [5:0] exp;
	} lct_row_t;

	localparam logic [9:0] VER   = 10'h155; // Arbitrary version code
	localparam lct_word_t  LEGAL = 16'h5a3c;

	logic       ref_clk, rst_b, reg_wr, reg_rd, msg_bcast;
	logic [3:0] reg_addr;
	logic [11:0] ev;
	logic [2:0] irq;
	logic [1:0] op;
	lct_word_t  reg_wdata, reg_rdata, msg_info, info_q, data;
	lct_word_t  host_wdata, mem_rdata, shared;
	logic       cs_n, rw_n, host_den, mem_den, wrs_n, wr_n, den;
	logic       pri_n, msg_n, term_n, exec, cha, chb, flag, dec, blk;
	int         n_errors, compares;
	int         hb [5] = '{15, 14, 13, 11, 10};
	lct_row_t   rows [5] = '{'{2'h0, 3'b000, 6'b110111},
		'{2'h1, 3'b100, 6'b001011}, '{2'h2, 3'b010, 6'b111101},
		'{2'h3, 3'b001, 6'b111110}, '{2'h0, 3'b111, 6'b110000}};

	// ------------------------------------------------------------
	// Design, far-side model and clock
	// ------------------------------------------------------------
	lct_terminal #(.legalization_preset_param(LEGAL), .version_code(VER)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reset_rt_code(ev[5]),
		.tx_shutdown_a(ev[6]), .tx_shutdown_b(ev[7]),
		.inhibit_flag_code(ev[8]), .msg_done(ev[11]),
		.msg_bcast(msg_bcast), .msg_info(msg_info), .tick_tag(ev[9]),
		.mon_msg_done(ev[10]), .mem_fail(ev[0]), .loop_fail(ev[1]),
		.tapar_err(ev[2]), .tout_a(ev[3]), .tout_b(ev[4]),
		.core_busy(irq[0]), .high_priority_irq(irq[2]),
		.message_irq(irq[1]), .legacy_chip_select_n(cs_n),
		.legacy_read_write_n(rw_n), .memory_read_data_in(mem_rdata),
		.host_write_data_in(host_wdata), .memory_data_out_enable(mem_den),
		.host_data_out_enable(host_den), .host_write_strobe_n(wrs_n),
		.host_write_n(wr_n), .legacy_shared_data_in(shared),
		.legacy_data_enable(den), .legacy_priority_irq_n(pri_n),
		.legacy_message_irq_n(msg_n), .terminal_active_n(term_n),
		.info_word_q(info_q), .execution_active(exec), .chan_a_en_q(cha),
		.chan_b_en_q(chb), .term_flag_en_q(flag), .decoder_reset_q(dec),
		.mon_blk_irq(blk));

	lct_host_model host (.ref_clk(ref_clk), .op(op), .data(data),
		.cs_n(cs_n), .rw_n(rw_n), .host_den(host_den), .mem_den(mem_den),
		.host_wdata(host_wdata), .mem_rdata(mem_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input lct_word_t got, input lct_word_t exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input lct_word_t d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input lct_word_t e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask

	// One-cycle event; its effect is visible just after the next edge
	task automatic pulse(input int i);
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		@(posedge ref_clk);
		ev <= '0;
		#1;
	endtask

	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly 130 cycles the tests need
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ev = '0;
		msg_bcast = 1'b0;
		msg_info = '0;
		irq = 3'h0;
		op = 2'h0;
		data = '0;
		n_errors = 0;
		compares = 0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Wrapper rows: pins follow their sources one cycle later
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk);
			op   <= rows[i].op;
			irq  <= rows[i].irq;
			data <= 16'h1357 ^ 16'(i);
			@(posedge ref_clk);
			#1;
			chk({10'h0, wrs_n, wr_n, den, pri_n, msg_n, term_n},
				{10'h0, rows[i].exp});
			if (rows[i].op != 2'h0) chk(shared, 16'h1357 ^ 16'(i));
		end
		op  <= 2'h0;
		irq <= 3'h0;
		done("wrapper");
		// Values after reset; host does all setting up itself
		rd(4'h6, {6'h0, VER});
		rd(4'hd, LEGAL);
		rd(4'h3, 16'h0000);
		chk({13'h0, cha, chb, flag}, 16'h0007);
		done("reset values");
		// Each fault sets only its own bit
		for (int j = 0; j < 5; j++) begin
			wr(4'h6, 16'h0000);
			pulse(j);
			rd(4'h6, 16'h0001 << hb[j]);
		end
		wr(4'h6, 16'h1fff);
		rd(4'h6, 16'h1fff);
		done("health");
		// Broadcast marking, with and without
		for (int b = 0; b < 2; b++) begin
			msg_info  <= 16'h0f0f;
			msg_bcast <= b[0];
			pulse(11);
			chk(info_q, 16'h0f0f | (16'(b) << 5));
		end
		done("broadcast");
		// Buffer-mode bit is only stored; RT enabled
		wr(4'h0, 16'h0041);
		rd(4'h0, 16'h0041);
		for (int k = 0; k < 3; k++) pulse(9);
		rd(4'h7, 16'h0003);
		pulse(6);
		pulse(7);
		pulse(8);
		rd(4'hc, 16'h0010);
		pulse(5);
		chk({15'h0, dec}, 16'h0001);
		chk({15'h0, exec}, 16'h0001);
		rd(4'h7, 16'h0000);
		rd(4'hc, 16'h001e);
		done("reset rt");
		// Monitor walk of four messages plus the extra one
		wr(4'h8, 16'h2000);
		wr(4'h9, 16'h0004);
		for (int k = 0; k < 7; k++) begin
			rd(4'hb, (k == 5) ? 16'h2000 : 16'h2000 + 16'(8 * (k % 5)));
			pulse(10);
			chk({15'h0, blk}, (k == 3) ? 16'h0001 : 16'h0000);
		end
		rd(4'ha, 16'h2018);
		done("monitor");
		// Second reset mid-run; host-written legal word must be preset again
		wr(4'hd, 16'h1234);
		rd(4'hd, 16'h1234);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(4'h6, {6'h0, VER});
		rd(4'hd, LEGAL);
		rd(4'hc, 16'h000e);
		done("second reset");
		stop_test;
	end
endmodule
`default_nettype wire
